/* fsk_consts.svh */
/*
  Constants of the FSK modem mode and tone control: tone frequencies, clock rate,
  carrier detect timing and hysteresis, mode pin codes.
  Assumes it is included by bare name from every file that needs a figure.
*/
`ifndef FSK_CONSTS_SVH
`define FSK_CONSTS_SVH

`define REF_CLK_HZ       64'd10000000
`define ACC_W            24
`define TONE_OUT_W       8
`define TONE_IDLE        8'h80

`define BELL_SPACE_LO_HZ 64'd1070
`define BELL_MARK_LO_HZ  64'd1270
`define BELL_SPACE_HI_HZ 64'd2025
`define BELL_MARK_HI_HZ  64'd2225
`define BELL_ECHO_HZ     64'd2225
`define V21_SPACE_LO_HZ  64'd1180
`define V21_MARK_LO_HZ   64'd980
`define V21_SPACE_HI_HZ  64'd1850
`define V21_MARK_HI_HZ   64'd1650
`define V21_ECHO_HZ      64'd2100

`define CD_ON_US_PER_NF  64'd6400
`define CD_OFF_US_PER_NF 64'd540
`define US_PER_S         64'd1000000
`define CD_HYST_DB       8'h03

`define LOOP_BIT_HI      1
`define LOOP_BIT_MID     0

`endif

/* fsk_pkg.sv */
/*
  Types of the FSK modem mode and tone control.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package fsk_pkg;
  typedef enum logic [1:0] {
    LOOP_LOW  = 2'b00,
    LOOP_MID  = 2'b01,
    LOOP_HIGH = 2'b11
  } loop_level_type;

  typedef enum logic [2:0] {
    MODE_NORMAL  = 3'b000,
    MODE_ECHO    = 3'b001,
    MODE_LOOP    = 3'b010,
    MODE_SQUELCH = 3'b011,
    MODE_DOWN    = 3'b100
  } op_mode_type;

  typedef enum logic {
    CD_ABSENT = 1'b0,
    CD_FOUND  = 1'b1
  } cd_state_type;
endpackage
`default_nettype wire

/* bit_stream_if.sv */
/*
  Valid/ready stream bundle between the control core and its data buffer.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ns
`default_nettype none
interface bit_stream_if #(parameter int WIDTH = 1);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* fifo_buf.sv */
/*
  Small flip-flop FIFO with valid/ready on both sides.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module fifo_buf #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  input  wire logic ref_clk,   // reference clock
  input  wire logic rst_n,     // async reset, low active
  bit_stream_if.snk wr,        // filling side
  bit_stream_if.src rd         // draining side
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  // honest full and empty from the fill count
  assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_q != '0);
  assign rd.data  = mem_q[rp_q];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  // storage write
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wp_q] <= wr.data;
    end
  end

  // pointers and count
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

/* fsk_mode_ctrl.sv */
/*
  Mode decode, tone synthesis and carrier detect timing of a 300 baud FSK modem.
  Assumes pins arrive asynchronous and pass two flops; the carrier level and the
  threshold and delay settings come from logic on ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fsk_consts.svh"
module fsk_mode_ctrl #(
  parameter bit          BELL          = 1'b1,  // 1 bell 103 tones, 0 v21 tones
  parameter int          CAP_W         = 16,    // width of delay capacitance in nF
  parameter int unsigned ON_CYC_PER_NF = 32'(`CD_ON_US_PER_NF * `REF_CLK_HZ / `US_PER_S),
  parameter int unsigned OFF_CYC_PER_NF = 32'(`CD_OFF_US_PER_NF * `REF_CLK_HZ / `US_PER_S)
) (
  input  wire logic                  ref_clk,           // 10 MHz reference clock
  input  wire logic                  rst_n,             // async reset, low active
  input  wire logic                  tx_data,           // serial transmit bit pin
  input  wire logic                  band_sel,          // high originate/ch1 pin
  input  wire logic                  tone_mute,         // squelch pin
  input  wire logic [1:0]            loop_echo_sel,     // window comparator of loop pin
  input  wire logic                  rx_bit_raw,        // demodulator slicer pin
  input  wire logic [7:0]            carrier_level,     // received level, dB steps
  input  wire logic [7:0]            carrier_level_adj, // on-threshold, dB steps
  input  wire logic [CAP_W-1:0]      carrier_delay_cap, // delay capacitance in nF
  output logic [`TONE_OUT_W-1:0]     line_tone_out,     // tone phase word
  output logic                       tone_on,           // modulator running
  output logic                       line_driver_en,    // line driver powered
  output logic                       loop_route,        // tx to rx analog switch
  output logic                       rx_low_band,       // demod uses low pair
  output logic                       power_down,        // chip powered down
  output logic                       carrier_found_n,   // low while carrier found
  output logic                       rx_data            // received data
);
  import fsk_pkg::*;

  logic [4:0]       meta_q;
  logic [4:0]       sync_q;
  logic             tx_s;
  logic             band_s;
  logic             mute_s;
  logic             rx_s;
  loop_level_type   loop_lvl;
  op_mode_type      mode;
  logic [`ACC_W-1:0] tx_inc;
  logic [`ACC_W-1:0] phase_q;
  logic [7:0]       off_thr;
  logic             above_on;
  logic             below_off;
  cd_state_type     cd_q;
  logic [31:0]      pre_q;
  logic [CAP_W:0]   unit_q;
  logic [31:0]      pre_lim;
  logic             unit_tick;
  logic             cd_arm;
  bit_stream_if #(.WIDTH(1)) fill ();
  bit_stream_if #(.WIDTH(1)) drain ();

  // phase step for a frequency at the reference rate, rounded to nearest
  function automatic logic [`ACC_W-1:0] inc_of(input logic [63:0] hz);
    logic [63:0] num;
    num = (hz << `ACC_W) + (`REF_CLK_HZ >> 1);
    return `ACC_W'(num / `REF_CLK_HZ);
  endfunction

  // two-flop synchronisers for the pins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 5'h00;
      sync_q <= 5'h00;
    end else begin
      meta_q <= {rx_bit_raw, loop_echo_sel, tone_mute, band_sel};
      sync_q <= meta_q;
    end
  end
  assign band_s = sync_q[0];
  assign mute_s = sync_q[1];
  assign rx_s   = sync_q[4];

  // three-level decode of the loop input
  always_comb begin
    if (sync_q[2+`LOOP_BIT_HI]) begin
      loop_lvl = LOOP_HIGH;
    end else if (sync_q[2+`LOOP_BIT_MID]) begin
      loop_lvl = LOOP_MID;
    end else begin
      loop_lvl = LOOP_LOW;
    end
  end

  // operating mode from mute and loop level
  always_comb begin
    case ({mute_s, loop_lvl})
      {1'b0, LOOP_LOW}:  mode = MODE_NORMAL;
      {1'b0, LOOP_MID}:  mode = MODE_ECHO;
      {1'b0, LOOP_HIGH}: mode = MODE_LOOP;
      {1'b1, LOOP_HIGH}: mode = MODE_DOWN;
      default:           mode = MODE_SQUELCH;
    endcase
  end

  // transmit bits pass through the buffer; it stalls outside normal and loopback modes
  logic tx_meta_q;
  logic tx_sync_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_meta_q <= 1'b1;
      tx_sync_q <= 1'b1;
    end else begin
      tx_meta_q <= tx_data;
      tx_sync_q <= tx_meta_q;
    end
  end
  assign fill.valid  = 1'b1;
  assign fill.data   = tx_sync_q;
  assign drain.ready = (mode == MODE_NORMAL) || (mode == MODE_LOOP);
  fifo_buf #(.WIDTH(1), .DEPTH(4)) tx_buf (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .wr      (fill),
    .rd      (drain)
  );
  assign tx_s = drain.valid ? drain.data : 1'b1;

  // tone choice: band and bit pick the pair member, echo overrides
  always_comb begin
    if (mode == MODE_ECHO) begin
      tx_inc = BELL ? inc_of(`BELL_ECHO_HZ) : inc_of(`V21_ECHO_HZ);
    end else if (BELL) begin
      if (band_s) begin
        tx_inc = tx_s ? inc_of(`BELL_MARK_LO_HZ) : inc_of(`BELL_SPACE_LO_HZ);
      end else begin
        tx_inc = tx_s ? inc_of(`BELL_MARK_HI_HZ) : inc_of(`BELL_SPACE_HI_HZ);
      end
    end else begin
      if (band_s) begin
        tx_inc = tx_s ? inc_of(`V21_MARK_LO_HZ) : inc_of(`V21_SPACE_LO_HZ);
      end else begin
        tx_inc = tx_s ? inc_of(`V21_MARK_HI_HZ) : inc_of(`V21_SPACE_HI_HZ);
      end
    end
  end

  // phase accumulator, held at zero while no tone is wanted
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= '0;
      tone_on <= 1'b0;
    end else if ((mode == MODE_SQUELCH) || (mode == MODE_DOWN)) begin
      phase_q <= '0;
      tone_on <= 1'b0;
    end else begin
      phase_q <= phase_q + tx_inc;
      tone_on <= 1'b1;
    end
  end

  // registered tone word, idle level when silent
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_tone_out <= `TONE_IDLE;
    end else if (tone_on) begin
      line_tone_out <= phase_q[`ACC_W-1 -: `TONE_OUT_W];
    end else begin
      line_tone_out <= `TONE_IDLE;
    end
  end

  // analog path switches and power state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_driver_en <= 1'b0;
      loop_route     <= 1'b0;
      rx_low_band    <= 1'b0;
      power_down     <= 1'b0;
    end else begin
      power_down     <= (mode == MODE_DOWN);
      loop_route     <= (mode == MODE_LOOP);
      line_driver_en <= (mode != MODE_DOWN) &&
                        !((mode == MODE_SQUELCH) && (loop_lvl != LOOP_LOW));
      // normal hears the far pair; loopback hears its own transmit pair
      rx_low_band    <= (mode == MODE_LOOP) ? band_s : !band_s;
    end
  end

  // carrier thresholds with fixed hysteresis
  assign off_thr   = (carrier_level_adj > `CD_HYST_DB) ?
                     (carrier_level_adj - `CD_HYST_DB) : 8'h00;
  assign above_on  = (carrier_level >= carrier_level_adj);
  assign below_off = (carrier_level < off_thr);
  assign cd_arm    = (mode != MODE_DOWN) &&
                     ((cd_q == CD_ABSENT) ? above_on : below_off);
  assign pre_lim   = (cd_q == CD_ABSENT) ? ON_CYC_PER_NF : OFF_CYC_PER_NF;
  assign unit_tick = (pre_q >= pre_lim - 32'd1);

  // delay timer: prescaler per nF, then units of capacitance
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q  <= '0;
      unit_q <= '0;
    end else if (!cd_arm || (unit_q > {1'b0, carrier_delay_cap})) begin
      pre_q  <= '0;
      unit_q <= '0;
    end else if (unit_tick) begin
      pre_q  <= '0;
      unit_q <= unit_q + 1'b1;
    end else begin
      pre_q  <= pre_q + 32'd1;
    end
  end

  // carrier state: flips once the level held past the delay; power down drops a found carrier at once
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cd_q <= CD_ABSENT;
    end else begin
      case (cd_q)
        CD_ABSENT: begin
          if (cd_arm && (unit_q > {1'b0, carrier_delay_cap})) begin
            cd_q <= CD_FOUND;
          end
        end
        CD_FOUND: begin
          if (mode == MODE_DOWN) begin
            cd_q <= CD_ABSENT;
          end else if (cd_arm && (unit_q > {1'b0, carrier_delay_cap})) begin
            cd_q <= CD_ABSENT;
          end
        end
        default: cd_q <= CD_ABSENT;
      endcase
    end
  end

  // registered carrier flag and clamped data
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      carrier_found_n <= 1'b1;
      rx_data         <= 1'b1;
    end else begin
      carrier_found_n <= (cd_q != CD_FOUND);
      rx_data         <= (cd_q != CD_FOUND) ? 1'b1 : rx_s;
    end
  end

  // checks on the outputs, the tone steps and the carrier state
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  rx_clamp_high_a: assert property (carrier_found_n |-> rx_data)
    else $error("rx data not high without carrier");
  rx_follow_a: assert property ((cd_q == CD_FOUND) |=> (rx_data == $past(rx_s)))
    else $error("rx data not following demodulator");
  squelch_silent_a: assert property ((mode == MODE_SQUELCH) |=> !tone_on ##1
                                     (line_tone_out == `TONE_IDLE))
    else $error("tone present in squelch");
  down_state_a: assert property ((mode == MODE_DOWN) && $past(mode == MODE_DOWN) |=>
                                 power_down && !line_driver_en && !tone_on && carrier_found_n)
    else $error("power down incomplete");
  echo_tone_a: assert property ((mode == MODE_ECHO) |-> (tx_inc == (BELL ?
                                inc_of(`BELL_ECHO_HZ) : inc_of(`V21_ECHO_HZ))))
    else $error("wrong echo tone");
  mark_orig_a: assert property ((mode == MODE_NORMAL) && band_s && tx_s |-> (tx_inc ==
                                (BELL ? inc_of(`BELL_MARK_LO_HZ) : inc_of(`V21_MARK_LO_HZ))))
    else $error("wrong originate mark tone");
  loop_band_a: assert property ((mode == MODE_LOOP) |=> loop_route &&
                                (rx_low_band == $past(band_s)))
    else $error("loopback receive pair wrong");
  driver_on_a: assert property ((mode == MODE_SQUELCH) && (loop_lvl == LOOP_LOW)
                                |=> line_driver_en)
    else $error("line driver off in squelch");
  phase_step_a: assert property (tone_on && $past(tone_on) && (mode == MODE_NORMAL)
                                 |-> (phase_q == $past(phase_q) + $past(tx_inc)))
    else $error("phase accumulator step wrong");
  cd_rise_cause_a: assert property ($rose(cd_q == CD_FOUND) |-> $past(above_on))
    else $error("carrier found without level");
  cd_fall_cause_a: assert property ($fell(cd_q == CD_FOUND) && $past(mode) != MODE_DOWN
                                    |-> $past(below_off))
    else $error("carrier lost without low level");
  hyst_a: assert property ((carrier_level_adj > `CD_HYST_DB) |->
                           (carrier_level_adj - off_thr == `CD_HYST_DB))
    else $error("hysteresis not 3 dB");
endmodule
`default_nettype wire

/* line_model.sv */
/*
  Far-side model: line level and demodulator slicer bit for the mode control.
  Assumes the bench sets the wanted line level off the rising edge.
*/
`timescale 1ns/1ns
`default_nettype none
module line_model (
  input  wire logic       ref_clk,       // reference clock
  input  wire logic       rst_n,         // async reset, low active
  input  wire logic [7:0] sig_level,     // wanted line level, dB steps
  input  wire logic       loop_route,    // loopback switch from dut
  input  wire logic       tx_data,       // terminal transmit bit
  output logic [7:0]      carrier_level, // level seen by dut
  output logic            rx_bit_raw,    // slicer bit to dut
  output logic [3:0]      bit_phase      // cycle within a received bit
);
  logic [3:0] cnt_q; // cycle within the current bit
  logic [7:0] pat_q; // received pattern, rotates once per bit
  // one bit every 16 cycles, so the slicer never sits still for long
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      pat_q <= 8'h4d;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == 4'hf) begin
        pat_q <= {pat_q[6:0], pat_q[7]};
      end
    end
  end
  // in loopback the slicer hears the own transmit bit
  assign rx_bit_raw    = loop_route ? tx_data : pat_q[7];
  assign carrier_level = sig_level;
  assign bit_phase     = cnt_q;
endmodule
`default_nettype wire

/* tb.sv */
/*
  Self-checking bench of the modem mode control and its data buffer.
  Assumes the design files are compiled first; one clock of 10 MHz.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int ON_CYC  = 8;
  localparam int OFF_CYC = 3;
  localparam int CAP     = 2;
  logic        ref_clk, rst_n, tx_data, band_sel, tone_mute, rx_bit_raw;
  logic [1:0]  loop_echo_sel;
  logic [7:0]  carrier_level, sig_level, carrier_level_adj, line_tone_out;
  logic [15:0] carrier_delay_cap;
  logic        tone_on, line_driver_en, loop_route, rx_low_band, power_down;
  logic        carrier_found_n, rx_data;
  logic [3:0]  bit_phase;
  int          fails, checks;

  fsk_mode_ctrl #(
    .BELL           (1'b1),
    .CAP_W          (16),
    .ON_CYC_PER_NF  (ON_CYC),
    .OFF_CYC_PER_NF (OFF_CYC)
  ) dut (
    .ref_clk, .rst_n, .tx_data, .band_sel, .tone_mute, .loop_echo_sel, .rx_bit_raw,
    .carrier_level, .carrier_level_adj, .carrier_delay_cap, .line_tone_out, .tone_on,
    .line_driver_en, .loop_route, .rx_low_band, .power_down, .carrier_found_n, .rx_data
  );
  line_model line (
    .ref_clk, .rst_n, .sig_level, .loop_route, .tx_data, .carrier_level, .rx_bit_raw,
    .bit_phase
  );

  // free-running reference clock
  always #50 ref_clk = ~ref_clk;

  task give_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task check_bits(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task check_range(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // counts falling edges until the carrier flag shows v
  task wait_flag(input logic v, output int c);
    c = 0;
    while (carrier_found_n !== v && c < 1000) begin
      @(negedge ref_clk);
      c++;
    end
    if (c >= 1000) begin
      fails++;
      give_verdict();
    end
  endtask

  // every mute, loop code and band; outputs judged once settled
  task t_modes;
    logic [3:0] exp;
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 4; s++) begin
        for (int b = 0; b < 2; b++) begin
          tone_mute = m[0];
          loop_echo_sel = s[1:0];
          band_sel = b[0];
          repeat (6) @(negedge ref_clk);
          exp = {!m[0], !(m[0] && (s[1] || s == 1)), !m[0] && s[1], m[0] && s[1]};
          check_bits({tone_on, line_driver_en, loop_route, power_down}, exp);
          if (!m[0]) check_bits(rx_low_band, s[1] ? b[0] : !b[0]);
          if (m[0]) check_bits(line_tone_out, 8'h80);
        end
      end
    end
    tone_mute = 1'b0;
    loop_echo_sel = 2'b00;
    $display("test modes done");
  endtask

  // one tone period measured between two wraps of the phase word
  task t_tone(input logic b, input logic [1:0] s, input logic d, input int f);
    int  c;
    logic prev;
    band_sel = b;
    loop_echo_sel = s;
    tx_data = d;
    repeat (20) @(negedge ref_clk);
    for (int k = 0; k < 2; k++) begin
      c = 0;
      do begin
        prev = line_tone_out[7];
        @(negedge ref_clk);
        c++;
      end while (!(prev === 1'b1 && line_tone_out[7] === 1'b0) && c < 30000);
      if (c >= 30000) begin
        fails++;
        give_verdict();
      end
    end
    check_range(10000000 / c, f - 5, f + 5);
    $display("test tone %0d done", f);
  endtask

  // carrier flag timing, dip restart, hysteresis and data clamp
  task t_carrier;
    int c;
    sig_level = 8'h19;
    repeat (20) @(negedge ref_clk);
    check_bits(carrier_found_n, 1'b1);
    check_bits(rx_data, 1'b1);
    sig_level = 8'h10;
    @(negedge ref_clk);
    sig_level = 8'h14;
    wait_flag(1'b0, c);
    check_range(c, (CAP + 1) * ON_CYC - 2, (CAP + 1) * ON_CYC + 6);
    for (int k = 0; k < 64; k++) begin
      @(negedge ref_clk);
      if (bit_phase == 4'h8) check_bits(rx_data, rx_bit_raw);
    end
    sig_level = 8'h11;
    repeat (60) @(negedge ref_clk);
    check_bits(carrier_found_n, 1'b0);
    sig_level = 8'h10;
    wait_flag(1'b1, c);
    check_range(c, (CAP + 1) * OFF_CYC - 2, (CAP + 1) * OFF_CYC + 6);
    for (int k = 0; k < 64; k++) begin
      @(negedge ref_clk);
      if (bit_phase == 4'h8) check_bits(rx_data, 1'b1);
    end
    $display("test carrier done");
  endtask

  // transmit buffer through the top: fills with spaces in squelch, drains after
  task t_fifo;
    int n;
    tx_data = 1'b0;
    repeat (4) @(negedge ref_clk);
    tone_mute = 1'b1;
    repeat (10) @(negedge ref_clk);
    check_bits(dut.fill.ready, 1'b0);
    check_bits(dut.drain.valid, 1'b1);
    tx_data = 1'b1;
    repeat (4) @(negedge ref_clk);
    check_bits(dut.drain.data, 1'b0);
    tone_mute = 1'b0;
    n = 0;
    for (int k = 0; k < 16; k++) begin
      @(negedge ref_clk);
      if (dut.drain.valid === 1'b1 && dut.drain.ready === 1'b1 &&
          dut.drain.data === 1'b0) n++;
    end
    check_range(n, 4, 4);
    check_bits(dut.drain.data, 1'b1);
    $display("test fifo done");
  endtask

  // main sequence
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    tx_data = 1'b1;
    band_sel = 1'b1;
    tone_mute = 1'b0;
    loop_echo_sel = 2'b00;
    sig_level = 8'h00;
    carrier_level_adj = 8'h14;
    carrier_delay_cap = 16'h0002;
    fails = 0;
    checks = 0;
    repeat (3) @(negedge ref_clk);
    check_bits({line_tone_out}, 8'h80);
    check_bits({tone_on, line_driver_en, loop_route, rx_low_band, power_down}, 8'h00);
    check_bits({carrier_found_n, rx_data}, 8'h03);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    t_modes();
    t_tone(1'b1, 2'b00, 1'b1, 1270);
    t_tone(1'b1, 2'b00, 1'b0, 1070);
    t_tone(1'b0, 2'b00, 1'b1, 2225);
    t_tone(1'b0, 2'b00, 1'b0, 2025);
    t_tone(1'b0, 2'b01, 1'b0, 2225);
    loop_echo_sel = 2'b00;
    t_carrier();
    t_fifo();
    give_verdict();
  end
endmodule
`default_nettype wire
